//--- rtl/fwm_bit_mark.sv
`timescale 1ns/1ns
`default_nettype none
// Applies one payload bit to a sample by XOR into the LSB; bypass passes bit-exact
module fwm_bit_mark (
  // Sample in
  input wire logic [fwm_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic mark_en_i,
  input wire logic bit_i,
  // Sample out
  output logic [fwm_pkg::SAMPLE_W-1:0] sample_o
);
  // Unmarked samples are copied unchanged
  always_comb begin
    sample_o = sample_i;
    if (mark_en_i) begin
      sample_o[0] = sample_i[0] ^ bit_i;
    end
  end
endmodule
`default_nettype wire

//--- rtl/fwm_mark_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module fwm_mark_ctrl (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [fwm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Timing and composition
  input wire logic quarter_tick_i,
  input wire logic comp_start_i,
  input wire logic comp_end_i,
  // Audio in
  input wire logic aud_valid_i,
  input wire logic [fwm_pkg::NUM_CHAN*fwm_pkg::SAMPLE_W-1:0] aud_data_i,
  // Image in
  input wire logic img_valid_i,
  input wire logic [fwm_pkg::SAMPLE_W-1:0] img_data_i,
  // Audio out
  output logic aud_valid_o,
  output logic [fwm_pkg::NUM_CHAN*fwm_pkg::SAMPLE_W-1:0] aud_data_o,
  // Image out
  output logic img_valid_o,
  output logic [fwm_pkg::SAMPLE_W-1:0] img_data_o,
  // Status
  output logic comp_active_o,
  output logic [fwm_pkg::BIT_IDX_W-1:0] bit_idx_o
);
  typedef enum logic [0:0] {IDLE, PLAY} comp_state_type;

  comp_state_type state_q;
  logic [31:0] ctrl_q;
  logic [fwm_pkg::STAMP_W-1:0] stamp_q;
  logic [fwm_pkg::LOC_W-1:0] loc_q;
  logic [31:0] repeat_q;
  logic [31:0] rep_cnt_q;
  logic [fwm_pkg::BIT_IDX_W-1:0] bit_idx_q;
  logic [fwm_pkg::PAYLOAD_W-1:0] payload_q;
  logic img_off_q;
  logic aud_off_q;
  logic sel_q;
  logic [fwm_pkg::CHAN_NUM_W-1:0] thr_q;
  logic cur_bit;
  logic [fwm_pkg::NUM_CHAN*fwm_pkg::SAMPLE_W-1:0] aud_mark;
  logic [fwm_pkg::SAMPLE_W-1:0] img_mark;
  logic [fwm_pkg::NUM_CHAN-1:0] chan_en;

  // Channel numbered ch (1-based) is marked under the latched settings
  function automatic logic chan_marked(input int unsigned ch, input logic aud_off, input logic sel,
                                       input logic [fwm_pkg::CHAN_NUM_W-1:0] thr);
    logic r;
    r = 1'b1;
    if (sel) begin
      r = (thr > fwm_pkg::CHAN_NUM_W'(fwm_pkg::NUM_CHAN)) || (fwm_pkg::CHAN_NUM_W'(ch) <= thr);
    end else if (aud_off) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // Composition state
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= IDLE;
    end else begin
      case (state_q)
        IDLE: begin
          if (comp_start_i) begin
            state_q <= PLAY;
          end
        end
        PLAY: begin
          if (comp_end_i) begin
            state_q <= IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Latch disable and threshold at composition start only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      img_off_q <= 1'b0;
      aud_off_q <= 1'b0;
      sel_q <= 1'b0;
      thr_q <= '0;
    end else if (state_q == IDLE && comp_start_i) begin
      img_off_q <= ctrl_q[fwm_pkg::CTRL_IMG_OFF_BIT];
      aud_off_q <= ctrl_q[fwm_pkg::CTRL_AUD_OFF_BIT];
      sel_q <= ctrl_q[fwm_pkg::CTRL_SEL_BIT];
      thr_q <= ctrl_q[fwm_pkg::CTRL_THR_LSB +: fwm_pkg::CHAN_NUM_W];
    end
  end

  // Software registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
      loc_q <= '0;
      repeat_q <= fwm_pkg::REPEAT_DEFAULT;
    end else if (wr_i) begin
      case (addr_i)
        fwm_pkg::CTRL_ADDR: ctrl_q <= wdata_i;
        fwm_pkg::LOC_ADDR: loc_q <= wdata_i[fwm_pkg::LOC_W-1:0];
        fwm_pkg::REPEAT_ADDR: repeat_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // Quarter-hour timestamp, wraps after the last quarter hour of a 366-day year
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stamp_q <= '0;
    end else if (wr_i && addr_i == fwm_pkg::STAMP_ADDR) begin
      stamp_q <= wdata_i[fwm_pkg::STAMP_W-1:0];
    end else if (quarter_tick_i) begin
      stamp_q <= (stamp_q >= fwm_pkg::STAMP_LAST) ? '0 : stamp_q + 1'b1;
    end
  end

  // Payload bit walk: one bit per repeat interval slice, snapshot at each cycle start
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rep_cnt_q <= '0;
      bit_idx_q <= '0;
      payload_q <= '0;
    end else if (state_q == IDLE) begin
      rep_cnt_q <= '0;
      bit_idx_q <= '0;
      payload_q <= {stamp_q, loc_q};
    end else if (aud_valid_i) begin
      if (rep_cnt_q + 32'h1 >= repeat_q) begin
        rep_cnt_q <= '0;
        if (bit_idx_q == fwm_pkg::BIT_LAST) begin
          bit_idx_q <= '0;
          payload_q <= {stamp_q, loc_q};
        end else begin
          bit_idx_q <= bit_idx_q + 1'b1;
        end
      end else begin
        rep_cnt_q <= rep_cnt_q + 32'h1;
      end
    end
  end

  assign cur_bit = payload_q[fwm_pkg::PAYLOAD_W - 1 - bit_idx_q];

  // Per-channel marking, same payload in every channel and the image
  generate
    for (genvar ch = 0; ch < fwm_pkg::NUM_CHAN; ch++) begin : g_chan
      assign chan_en[ch] = (state_q == PLAY) && chan_marked(ch + 1, aud_off_q, sel_q, thr_q);
      fwm_bit_mark u_mark (
        .sample_i(aud_data_i[ch*fwm_pkg::SAMPLE_W +: fwm_pkg::SAMPLE_W]),
        .mark_en_i(chan_en[ch]),
        .bit_i(cur_bit),
        .sample_o(aud_mark[ch*fwm_pkg::SAMPLE_W +: fwm_pkg::SAMPLE_W])
      );
    end
  endgenerate

  fwm_bit_mark u_img_mark (
    .sample_i(img_data_i),
    .mark_en_i((state_q == PLAY) && !img_off_q),
    .bit_i(cur_bit),
    .sample_o(img_mark)
  );

  // Audio output: every valid sample forwarded in order, one cycle late
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aud_valid_o <= 1'b0;
      aud_data_o <= '0;
    end else begin
      aud_valid_o <= aud_valid_i;
      if (aud_valid_i) begin
        aud_data_o <= aud_mark;
      end
    end
  end

  // Image output
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      img_valid_o <= 1'b0;
      img_data_o <= '0;
    end else begin
      img_valid_o <= img_valid_i;
      if (img_valid_i) begin
        img_data_o <= img_mark;
      end
    end
  end

  // Status outputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      comp_active_o <= 1'b0;
      bit_idx_o <= '0;
    end else begin
      comp_active_o <= (state_q == PLAY);
      bit_idx_o <= bit_idx_q;
    end
  end

  // Read data one cycle after the strobe, zero otherwise and for unmapped addresses
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        fwm_pkg::CTRL_ADDR: rdata_o <= ctrl_q;
        fwm_pkg::STAMP_ADDR: rdata_o <= {16'h0000, stamp_q};
        fwm_pkg::LOC_ADDR: rdata_o <= {12'h000, loc_q};
        fwm_pkg::STATUS_ADDR: rdata_o <= {fwm_pkg::LOC_W_REPORT[15:0], 9'h000, bit_idx_q, (state_q == PLAY)};
        fwm_pkg::REPEAT_ADDR: rdata_o <= repeat_q;
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // Bypassed channels equal source one cycle later
  property p_bypass_exact;
    @(posedge core_clk_i) disable iff (rst_i)
      (aud_valid_i && state_q == PLAY && sel_q && thr_q == 7'h06)
      |=> aud_data_o[fwm_pkg::NUM_CHAN*fwm_pkg::SAMPLE_W-1:6*fwm_pkg::SAMPLE_W]
          == $past(aud_data_i[fwm_pkg::NUM_CHAN*fwm_pkg::SAMPLE_W-1:6*fwm_pkg::SAMPLE_W]);
  endproperty
  chk_sel_bypass_exact: assert property (p_bypass_exact) else $error("bypassed channel altered");

  chk_nomark_exact: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (aud_valid_i && (state_q == IDLE || (aud_off_q && !sel_q))) |=> aud_data_o == $past(aud_data_i))
    else $error("no-mark audio altered");

  chk_valid_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    aud_valid_i |=> aud_valid_o) else $error("audio sample dropped");

  chk_no_insert: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !aud_valid_i |=> !aud_valid_o) else $error("audio sample inserted");

  chk_stamp_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (quarter_tick_i && !wr_i && stamp_q == fwm_pkg::STAMP_LAST) |=> stamp_q == '0)
    else $error("timestamp wrap wrong");

  chk_stamp_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (quarter_tick_i && !wr_i && stamp_q < fwm_pkg::STAMP_LAST) |=> stamp_q == $past(stamp_q) + 16'h0001)
    else $error("timestamp step wrong");

  chk_latch_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_q == PLAY) |=> $stable(thr_q) && $stable(aud_off_q) && $stable(sel_q))
    else $error("settings changed mid composition");

  chk_thr_all: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_q == PLAY && sel_q && thr_q > 7'h10) |-> &chan_en)
    else $error("high threshold not marking all");

  chk_idle_unmarked: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_q == IDLE) |-> chan_en == '0) else $error("marking outside composition");

  // Image passes bit-exact whenever its marking is off
  chk_img_bypass: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (img_valid_i && (state_q == IDLE || img_off_q)) |=> img_data_o == $past(img_data_i))
    else $error("unmarked image altered");

  // A start taken in idle enters play and shows as active one edge later
  sequence s_start_taken;
    state_q == IDLE && comp_start_i;
  endsequence
  sequence s_play_shown;
    state_q == PLAY ##1 comp_active_o;
  endsequence
  chk_comp_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_start_taken |=> s_play_shown) else $error("composition start not taken");

  // Each composition begins its payload walk at the first bit
  chk_walk_restart: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_start_taken |=> (bit_idx_q == '0) && (rep_cnt_q == '0)) else $error("payload walk not restarted");

  // Bit index never passes the last payload bit
  chk_bit_range: assert property (@(posedge core_clk_i) disable iff (rst_i)
    bit_idx_q <= fwm_pkg::BIT_LAST) else $error("payload bit index out of range");

  // Read data fall back to zero outside the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == '0) else $error("read data outside read cycle");
endmodule
`default_nettype wire

//--- rtl/fwm_pkg.sv
package fwm_pkg;
  // Channel layout
  localparam int unsigned NUM_CHAN = 16;
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned CHAN_NUM_W = 7;
  // Payload layout
  localparam int unsigned STAMP_W = 16;
  localparam int unsigned LOC_W = 20;
  localparam int unsigned PAYLOAD_W = STAMP_W + LOC_W;
  localparam int unsigned BIT_IDX_W = 6;
  // Last quarter-hour index of a 366-day year
  localparam logic [STAMP_W-1:0] STAMP_LAST = 16'h893f;
  // Register bus
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STAMP_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] LOC_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] REPEAT_ADDR = 4'h4;
  // Control register fields
  localparam int unsigned CTRL_IMG_OFF_BIT = 0;
  localparam int unsigned CTRL_AUD_OFF_BIT = 1;
  localparam int unsigned CTRL_SEL_BIT = 2;
  localparam int unsigned CTRL_THR_LSB = 8;
  localparam logic [31:0] LOC_W_REPORT = 32'h0000_0014;
  // Default samples per payload bit: all 36 bits well inside five minutes at 48 kHz
  localparam logic [31:0] REPEAT_DEFAULT = 32'h0002_bf20;
  // Last bit index within payload
  localparam logic [BIT_IDX_W-1:0] BIT_LAST = 6'h23;
endpackage

//--- verif/essence_src.sv
`timescale 1ns/1ns
`default_nettype none
// Essence source that sends sample groups on random cycles
module essence_src (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  // Essence out
  output logic valid_o = 1'b0,
  output logic [fwm_pkg::NUM_CHAN*fwm_pkg::SAMPLE_W-1:0] aud_o = '0,
  output logic [fwm_pkg::SAMPLE_W-1:0] img_o = '0
);
  integer seed = 32'hf97d;
  logic [31:0] r;
  // Idle data lines invert so stale values never look valid
  always @(posedge core_clk_i) begin
    r = $random(seed);
    valid_o <= !rst_i && en_i && r[0];
    if (!rst_i && en_i && r[0]) begin
      for (int i = 0; i < 12; i++) aud_o[i*32+:32] <= $random(seed);
      img_o <= r[31:8];
    end else begin
      aud_o <= ~aud_o;
      img_o <= ~img_o;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam int AW = fwm_pkg::NUM_CHAN*fwm_pkg::SAMPLE_W;
  // Last quarter hour of a 366-day year, and samples per payload bit in the test
  localparam int LAST_Q = 366*96-1;
  localparam int REP = 3;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] pul = '0;
  logic src_en = 1'b0;
  logic vin, aud_valid_o, img_valid_o, comp_active_o;
  logic [AW-1:0] aud_data_i, aud_data_o;
  logic [23:0] img_data_i, img_data_o;
  logic [31:0] rdata_o, v, lat, lm;
  logic [AW+23:0] exp_q[$], msk_q[$], m, lmask;
  logic [31:0] tbl [7] = '{32'h2, 32'h0606, 32'h0804, 32'h1104, 32'h0001, 32'h0a04, 32'h0};
  integer seed = 32'hf97d;
  int fail_count = 0;
  int num_checks = 0;
  int flips = 0;
  int nsamp = 0;
  logic [5:0] bidx;
  // Clock
  always #2 core_clk_i = ~core_clk_i;
  fwm_mark_ctrl dut (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .quarter_tick_i(pul[0]), .comp_start_i(pul[1]), .comp_end_i(pul[2]), .aud_valid_i(vin), .aud_data_i,
    .img_valid_i(vin), .img_data_i, .aud_valid_o, .aud_data_o, .img_valid_o, .img_data_o, .comp_active_o,
    .bit_idx_o(bidx));
  essence_src src (.core_clk_i, .rst_i, .en_i(src_en), .valid_o(vin), .aud_o(aud_data_i), .img_o(img_data_i));
  // Cleared mask bit means a marked LSB that may differ
  function automatic logic [AW+23:0] mask_of(input logic [31:0] c);
    logic [AW+23:0] r;
    r = '1;
    for (int k = 1; k <= 16; k++) if (c[2] ? (c[14:8] > 16 || k <= c[14:8]) : !c[1]) r[(k-1)*24] = 1'b0;
    if (!c[0]) r[AW] = 1'b0;
    return r;
  endfunction
  // Note expected output for each sample taken
  always @(posedge core_clk_i) if (vin && !rst_i) begin
    exp_q.push_back({img_data_i, aud_data_i});
    msk_q.push_back(lmask);
    nsamp++;
  end
  // Compare each output against the oldest note
  always @(posedge core_clk_i) if (aud_valid_o === 1'b1) begin
    `CHK("pending", 1'b1, exp_q.size() > 0)
    m = msk_q.pop_front();
    `CHK("aud", exp_q[0][AW-1:0] & m[AW-1:0], aud_data_o & m[AW-1:0])
    `CHK("img", exp_q[0][AW+:24] & m[AW+:24], img_data_o & m[AW+:24])
    `CHK("imgv", 1'b1, img_valid_o)
    flips += |((aud_data_o ^ exp_q[0][AW-1:0]) & ~m[AW-1:0]);
    flips += |((img_data_o ^ exp_q[0][AW+:24]) & ~m[AW+:24]);
    void'(exp_q.pop_front());
  end
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task pulse(input int k);
    @(posedge core_clk_i);
    pul[k] <= 1'b1;
    @(posedge core_clk_i);
    pul <= '0;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
  // Main sequence
  initial begin
    lat = '0;
    lmask = '1;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(fwm_pkg::REPEAT_ADDR);
    `CHK("repeat", fwm_pkg::REPEAT_DEFAULT, v)
    rd(fwm_pkg::STATUS_ADDR);
    `CHK("locw", 16'h0014, v[31:16])
    rd(4'h9);
    `CHK("unmapped", 32'h0, v)
    wr(fwm_pkg::STAMP_ADDR, 32'(LAST_Q - 1));
    pulse(0);
    rd(fwm_pkg::STAMP_ADDR);
    `CHK("stamp", 32'(LAST_Q), v)
    pulse(0);
    rd(fwm_pkg::STAMP_ADDR);
    `CHK("wrap", 32'h0, v)
    wr(fwm_pkg::STAMP_ADDR, 32'hffff_1234);
    rd(fwm_pkg::STAMP_ADDR);
    `CHK("stampw", 32'h1234, v)
    lm = $random(seed);
    wr(fwm_pkg::LOC_ADDR, lm);
    rd(fwm_pkg::LOC_ADDR);
    `CHK("loc", lm & 32'hfffff, v)
    wr(fwm_pkg::REPEAT_ADDR, 32'(REP));
    foreach (tbl[i]) begin
      wr(fwm_pkg::CTRL_ADDR, tbl[i]);
      lat = tbl[i];
      lmask = mask_of(lat);
      flips = 0;
      nsamp = 0;
      pulse(1);
      repeat (2) @(posedge core_clk_i);
      #1 `CHK("active", 1'b1, comp_active_o)
      wr(fwm_pkg::CTRL_ADDR, ~tbl[i]);
      src_en <= 1'b1;
      repeat (60) @(posedge core_clk_i);
      src_en <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      `CHK("marked", !(&lmask), flips != 0)
      `CHK("bitidx", (nsamp / REP) % fwm_pkg::PAYLOAD_W, bidx)
      pulse(2);
      repeat (3) @(posedge core_clk_i);
    end
    `CHK("drain", 0, exp_q.size())
    print_verdict;
  end
endmodule
`default_nettype wire
